// ===== dv/cmsc_top_props.sv
/*
 Checker for the tuning decode and the hysteretic method choice.
 Assumes full-word writes; limits are trusted once three enabled edges pass.
*/
`timescale 1ns/1ps
`default_nettype none
module cmsc_top_props (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    input wire logic [7:0] bemf_samples_per_30deg,
    input wire logic [6:0] duty_percent,
    input wire logic [4:0] demag_check_sample_count,
    input wire logic [7:0] demag_upper_bound,
    input wire logic [7:0] demag_lower_bound,
    input wire logic [11:0] falling_phase_integ_limit,
    input wire logic [11:0] rising_phase_integ_limit,
    input wire logic zero_crossing_commutation
);
    // --------
    // Shadow word
    // --------
    logic [31:0] wd_r;
    logic [1:0] q_r;
    logic wr_full, ok, dn, up, zc;
    assign zc = zero_crossing_commutation;
    assign wr_full = clk_en && avs_write && avs_address == cmsc_pkg::TUNING_ADDR
        && avs_byteenable == 4'hF;
    assign ok = clk_en && q_r == 2'h3;
    assign dn = bemf_samples_per_30deg < cmsc_pkg::SLO_TBL[wd_r[24:23]];
    assign up = bemf_samples_per_30deg > cmsc_pkg::SHI_TBL[wd_r[22:21]]
        && duty_percent > cmsc_pkg::DUTY_TBL[wd_r[18:17]];
    // Copy of the tuning word as written
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wd_r <= cmsc_pkg::TUNING_RESET;
        end else if (wr_full) begin
            wd_r <= avs_writedata;
        end
    end
    // Wait three enabled edges after reset or any write before judging the selector
    always_ff @(posedge sys_clk) begin
        if (rst || avs_write) begin
            q_r <= 2'h0;
        end else if (clk_en && q_r != 2'h3) begin
            q_r <= q_r + 2'h1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence wr_seen;
        wr_full ##1 (clk_en && !avs_write);
    endsequence
    // --------
    // Assertions
    // --------
    dcnt_decode_a: assert property (wr_seen |=>
        demag_check_sample_count == cmsc_pkg::DCNT_TBL[wd_r[30:29]]) else $error("count decode");
    upper_decode_a: assert property (wr_seen |=>
        demag_upper_bound == cmsc_pkg::DUP_TBL[wd_r[28:27]]) else $error("upper decode");
    lower_decode_a: assert property (wr_seen |=>
        demag_lower_bound == cmsc_pkg::DLO_TBL[wd_r[26:25]]) else $error("lower decode");
    fall_decode_a: assert property (wr_seen |=>
        wd_r[16] || falling_phase_integ_limit == 12'(wd_r[15:11]) * 12'h019) else $error("fall");
    rise_decode_a: assert property (wr_seen |=>
        wd_r[10] || rising_phase_integ_limit == 12'(wd_r[9:5]) * 12'h019) else $error("rise");
    few_samples_a: assert property (ok && !zc && dn |=> zc) else $error("no switch");
    low_duty_a: assert property (
        ok && !zc && duty_percent < cmsc_pkg::DUTY_TBL[wd_r[20:19]] |=> zc) else $error("duty");
    back_integ_a: assert property (ok && zc && up |=> !zc) else $error("return");
    method_hold_a: assert property (ok && !(zc ? up : dn) && !(!zc && duty_percent <
        cmsc_pkg::DUTY_TBL[wd_r[20:19]]) |=> $stable(zc)) else $error("method moved");
    cover property (ok && !zc ##1 zc);
    cover property (ok && zc ##1 !zc);
    cover property (avs_read && !avs_waitrequest);
endmodule
bind cmsc_top cmsc_top_props u_props (.sys_clk, .rst, .clk_en, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .bemf_samples_per_30deg,
    .duty_percent, .demag_check_sample_count, .demag_upper_bound, .demag_lower_bound,
    .falling_phase_integ_limit, .rising_phase_integ_limit, .zero_crossing_commutation);
`default_nettype wire

// ===== dv/commutation_method_select_cfg_test.sv
/*
 Self-checking bench: register access, field decode, method hysteresis.
 Assumes the checker binds itself in.
*/
`timescale 1ns/1ps
`default_nettype none
module commutation_method_select_cfg_test;
    logic sys_clk, rst, clk_en, avs_read, avs_write, avs_waitrequest, m;
    logic dynamic_demag_enable, zero_crossing_commutation;
    logic [9:0] avs_address;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd, w;
    logic [7:0] bemf_samples_per_30deg, demag_upper_bound, demag_lower_bound;
    logic [6:0] duty_percent;
    logic [4:0] demag_check_sample_count;
    logic [11:0] falling_phase_integ_limit, rising_phase_integ_limit;
    logic [1:0] demag_max_window;
    int failures, n_compared, cyc;
    localparam logic [7:0] CNT_T [4] = '{8'h0F, 8'h14, 8'h1E, 8'h0C};
    localparam logic [7:0] UP_T [4] = '{8'h5A, 8'h78, 8'h96, 8'hB4};
    localparam logic [7:0] LO_T [4] = '{8'h1E, 8'h3C, 8'h5A, 8'h78};
    localparam logic [7:0] SL_T [4] = '{8'h03, 8'h04, 8'h06, 8'h08};
    localparam logic [7:0] SH_T [4] = '{8'h04, 8'h06, 8'h08, 8'h0A};
    localparam logic [7:0] DT_T [4] = '{8'h0C, 8'h0F, 8'h12, 8'h14};
    localparam logic [5:0] TC [4] = '{6'h1F, 6'h20, 6'h37, 6'h3F};
    cmsc_top uut (.sys_clk, .rst, .clk_en, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .bemf_samples_per_30deg, .duty_percent, .demag_check_sample_count,
        .demag_upper_bound, .demag_lower_bound, .falling_phase_integ_limit,
        .rising_phase_integ_limit, .demag_max_window, .dynamic_demag_enable,
        .zero_crossing_commutation);
    // Threshold steps widen in four segments
    function automatic logic [11:0] thr(input logic [5:0] c);
        if (c < 6'h20) return 12'(c) * 12'h019;
        if (c < 6'h30) return 12'h320 + 12'(c - 6'h20) * 12'h032;
        if (c < 6'h38) return 12'h640 + 12'(c - 6'h30) * 12'h064;
        return 12'h960 + 12'(c - 6'h38) * 12'h0C8;
    endfunction
    // Next method from the inputs sampled at this edge
    function automatic logic nxt(input logic s, input logic [31:0] c);
        if (!clk_en) return s;
        if (!s) return bemf_samples_per_30deg < SL_T[c[24:23]] || duty_percent < DT_T[c[20:19]];
        return !(bemf_samples_per_30deg > SH_T[c[22:21]] && duty_percent > DT_T[c[18:17]]);
    endfunction
    // --------
    // Bus and compare
    // --------
    task automatic bus(input logic r, input logic [9:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_read <= r;
        avs_write <= !r;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_cfg(input logic [31:0] c);
        chk("count", 32'(CNT_T[c[30:29]]), 32'(demag_check_sample_count));
        chk("upper", 32'(UP_T[c[28:27]]), 32'(demag_upper_bound));
        chk("lower", 32'(LO_T[c[26:25]]), 32'(demag_lower_bound));
        chk("falling", 32'(thr(c[16:11])), 32'(falling_phase_integ_limit));
        chk("rising", 32'(thr(c[10:5])), 32'(rising_phase_integ_limit));
        chk("enable", 32'(c[0]), 32'(dynamic_demag_enable));
        chk("window", 32'(c[2:1]), 32'(demag_max_window));
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Clock and hang guard
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            failures++;
            report_and_stop();
        end
    end
    // --------
    // Main sequence
    // --------
    initial begin
        {rst, clk_en, avs_read, avs_write, avs_address, avs_writedata} = {2'h3, 44'h0};
        avs_byteenable = 4'hF;
        bemf_samples_per_30deg = 8'h00;
        duty_percent = 7'h32;
        w = $urandom(17818);
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk_cfg(32'h14000000);
        bus(1'b0, 10'h004, 32'hFFFFFFFF);
        bus(1'b1, 10'h004, 32'h0);
        chk("unmapped", 32'h0, rd);
        bus(1'b1, 10'h228, 32'h0);
        chk("reset", 32'h14000000, rd);
        for (int i = 0; i < 24; i++) begin
            w = $urandom();
            if (i < 4) w[30:5] = {{7{2'(i)}}, TC[i], TC[3 - i]};
            bus(1'b0, 10'h228, w);
            bus(1'b1, 10'h228, 32'h0);
            chk("readback", w, rd);
            chk_cfg(w);
            // Zero samples have held the selector in crossing since the last step
            bus(1'b1, 10'h000, 32'h0);
            chk("status", 32'h00000001, rd);
            // Zero samples force crossing, which the model starts from
            m = 1'b1;
            repeat (40) begin
                @(posedge sys_clk);
                m = nxt(m, w);
                clk_en <= ($urandom_range(0, 7) != 0);
                bemf_samples_per_30deg <= 8'($urandom_range(0, 12));
                duty_percent <= 7'($urandom_range(8, 24));
                #1 chk("method", 32'(m), 32'(zero_crossing_commutation));
            end
            // Both quantities far above every high limit return to integration
            @(posedge sys_clk);
            clk_en <= 1'b1;
            bemf_samples_per_30deg <= 8'hFF;
            duty_percent <= 7'h64;
            bus(1'b1, 10'h000, 32'h0);
            chk("status", 32'h00000000, rd);
            bemf_samples_per_30deg <= 8'h00;
        end
        report_and_stop();
    end
endmodule
`default_nettype wire

// ===== hw/cmsc_if.sv
/*
 Decoded settings passed from the register file to the method selector.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface cmsc_if;
    logic [3:0] sample_count_low_limit;
    logic [3:0] sample_count_high_limit;
    logic [6:0] duty_low_limit;
    logic [6:0] duty_high_limit;
    // ----------------------------------------------------------------
    // Ends
    // ----------------------------------------------------------------
    modport src (
        output sample_count_low_limit,
        output sample_count_high_limit,
        output duty_low_limit,
        output duty_high_limit
    );
    modport dst (
        input sample_count_low_limit,
        input sample_count_high_limit,
        input duty_low_limit,
        input duty_high_limit
    );
endinterface
`default_nettype wire

// ===== hw/cmsc_method_sel.sv
/*
 Hysteretic choice between integration and zero-crossing commutation.
 Assumes sample count and duty inputs are synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module cmsc_method_sel (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    cmsc_if.dst cfg,
    input wire logic [7:0] bemf_samples_per_30deg,
    input wire logic [6:0] duty_percent,
    output logic zero_crossing_commutation
);
    cmsc_pkg::cmsc_method_t state_r;
    cmsc_pkg::cmsc_method_t state_nxt;
    logic go_cross;
    logic go_integ;

    // ----------------------------------------------------------------
    // Switching conditions
    // ----------------------------------------------------------------
    // Either quantity falling under its low limit forces crossing
    assign go_cross = (bemf_samples_per_30deg < {4'h0, cfg.sample_count_low_limit})
        || (duty_percent < cfg.duty_low_limit);
    // Return needs both quantities clear of their high limits
    assign go_integ = (bemf_samples_per_30deg > {4'h0, cfg.sample_count_high_limit})
        && (duty_percent > cfg.duty_high_limit);

    // Between the limits the method is held, which gives hysteresis
    always_comb begin
        case (state_r)
            cmsc_pkg::CMSC_INTEG: state_nxt = go_cross ? cmsc_pkg::CMSC_CROSS : state_r;
            cmsc_pkg::CMSC_CROSS: state_nxt = go_integ ? cmsc_pkg::CMSC_INTEG : state_r;
            default: state_nxt = cmsc_pkg::CMSC_INTEG;
        endcase
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= cmsc_pkg::CMSC_INTEG;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    assign zero_crossing_commutation = (state_r == cmsc_pkg::CMSC_CROSS);
endmodule
`default_nettype wire

// ===== hw/cmsc_pkg.sv
/*
 Constants for the commutation method select block: register offset, field
 positions, reset value and decode tables.
 Assumes a 32-bit Avalon-MM register bus with byte addressing.
*/
package cmsc_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] TUNING_IDX = 8'h8A;
    localparam logic [9:0] TUNING_ADDR = {TUNING_IDX, 2'b00};
    localparam logic [9:0] STATUS_ADDR = 10'h000;
    localparam logic [31:0] TUNING_RESET = 32'h14000000;
    localparam logic [31:0] TUNING_WMASK = 32'hFFFFFFFF;

    // ----------------------------------------------------------------
    // Field positions (low bit of each field)
    // ----------------------------------------------------------------
    localparam int PARITY_POS = 31;
    localparam int DCNT_POS = 29;
    localparam int DUP_POS = 27;
    localparam int DLO_POS = 25;
    localparam int SLO_POS = 23;
    localparam int SHI_POS = 21;
    localparam int DTLO_POS = 19;
    localparam int DTHI_POS = 17;
    localparam int FALL_POS = 11;
    localparam int RISE_POS = 5;
    localparam int METH_POS = 4;
    localparam int DWIN_POS = 1;
    localparam int DEN_POS = 0;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int RD_WAIT_CYCLES = 1;

    // Commutation methods, Gray along integration <-> crossing
    typedef enum logic [0:0] {
        CMSC_INTEG = 1'b0,
        CMSC_CROSS = 1'b1
    } cmsc_method_t;

    // Demag sample count per code: 15, 20, 30, 12
    localparam logic [4:0] DCNT_TBL [4] = '{5'h0F, 5'h14, 5'h1E, 5'h0C};
    // Upper bound drop below supply in mV: 90, 120, 150, 180
    localparam logic [7:0] DUP_TBL [4] = '{8'h5A, 8'h78, 8'h96, 8'hB4};
    // Lower bound in mV: 30, 60, 90, 120
    localparam logic [7:0] DLO_TBL [4] = '{8'h1E, 8'h3C, 8'h5A, 8'h78};
    // Sample-count switching limits
    localparam logic [3:0] SLO_TBL [4] = '{4'h3, 4'h4, 4'h6, 4'h8};
    localparam logic [3:0] SHI_TBL [4] = '{4'h4, 4'h6, 4'h8, 4'hA};
    // Duty limits in percent: 12, 15, 18, 20
    localparam logic [6:0] DUTY_TBL [4] = '{7'h0C, 7'h0F, 7'h12, 7'h14};
    // Threshold segment bases and steps
    localparam logic [11:0] THR_STEP1 = 12'h019;
    localparam logic [11:0] THR_STEP2 = 12'h032;
    localparam logic [11:0] THR_STEP3 = 12'h064;
    localparam logic [11:0] THR_STEP4 = 12'h0C8;
    localparam logic [11:0] THR_BASE2 = 12'h320;
    localparam logic [11:0] THR_BASE3 = 12'h640;
    localparam logic [11:0] THR_BASE4 = 12'h960;
    localparam logic [5:0] THR_SEG2 = 6'h20;
    localparam logic [5:0] THR_SEG3 = 6'h30;
    localparam logic [5:0] THR_SEG4 = 6'h38;
endpackage

// ===== hw/cmsc_top.sv
/*
 Commutation tuning register with Avalon-MM slave, field decode and the
 hysteretic method selector.
 Assumes a synchronous master on sys_clk; sample and duty inputs are on-clock.
*/
// Notes on behaviour
// - Demag check sample count comes from bits 30-29, codes 0..3 giving 15, 20, 30, 12.
// - Demag upper bound from bits 28-27 is supply minus 90, 120, 150, 180 mV, reset code 2.
// - Demag lower bound from bits 26-25 is 30, 60, 90, 120 mV, reset code 2.
// - Integration switches to crossing when samples per 30 deg fall below 3, 4, 6, 8.
// - Crossing switches to integration when samples per 30 deg exceed 4, 6, 8, 10 and duty is also above its high limit.
// - Integration switches to crossing when duty drops below 12, 15, 18, 20 percent.
// - Crossing switches to integration when duty rises above 12, 15, 18, 20 percent and samples also exceed their high limit.
// - Falling-phase integration limit is bits 16-11, stepping by 25 from zero, then by 50, 100 and 200 from codes 32, 48 and 56.
// - Rising-phase integration limit is bits 10-5, coded like the falling one.
`timescale 1ns/1ps
`default_nettype none
module cmsc_top (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] bemf_samples_per_30deg,
    input wire logic [6:0] duty_percent,
    output logic [4:0] demag_check_sample_count,
    output logic [7:0] demag_upper_bound,
    output logic [7:0] demag_lower_bound,
    output logic [11:0] falling_phase_integ_limit,
    output logic [11:0] rising_phase_integ_limit,
    output logic [1:0] demag_max_window,
    output logic dynamic_demag_enable,
    output logic zero_crossing_commutation
);
    logic [31:0] tuning_r;
    logic rd_done_r;
    logic [31:0] rdata_r;
    logic [4:0] demag_cnt_r;
    logic [7:0] demag_up_r;
    logic [7:0] demag_lo_r;
    logic [11:0] fall_r;
    logic [11:0] rise_r;
    logic zc_sel;
    cmsc_if cfg_bus ();

    // ----------------------------------------------------------------
    // Threshold decode, shared by both phase limits
    // ----------------------------------------------------------------
    // Piecewise-linear steps; multiply by shift-free constants keeps it small
    function automatic logic [11:0] thr_decode(input logic [5:0] code);
        logic [11:0] c;
        c = {6'h00, code};
        if (code < cmsc_pkg::THR_SEG2) begin
            thr_decode = 12'(c * cmsc_pkg::THR_STEP1);
        end else if (code < cmsc_pkg::THR_SEG3) begin
            thr_decode = 12'(cmsc_pkg::THR_BASE2
                + (c - {6'h00, cmsc_pkg::THR_SEG2}) * cmsc_pkg::THR_STEP2);
        end else if (code < cmsc_pkg::THR_SEG4) begin
            thr_decode = 12'(cmsc_pkg::THR_BASE3
                + (c - {6'h00, cmsc_pkg::THR_SEG3}) * cmsc_pkg::THR_STEP3);
        end else begin
            thr_decode = 12'(cmsc_pkg::THR_BASE4
                + (c - {6'h00, cmsc_pkg::THR_SEG4}) * cmsc_pkg::THR_STEP4);
        end
    endfunction

    // ----------------------------------------------------------------
    // Avalon-MM slave
    // ----------------------------------------------------------------
    // Writes finish at once; reads take one extra cycle so data is registered
    assign avs_waitrequest = avs_read && !rd_done_r;

    // Register write with byte lanes; all 32 bits are plain storage
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tuning_r <= cmsc_pkg::TUNING_RESET;
        end else if (clk_en && avs_write && avs_address == cmsc_pkg::TUNING_ADDR) begin
            for (int b = 0; b < 4; b++) begin
                if (avs_byteenable[b]) begin
                    tuning_r[b*8 +: 8] <= avs_writedata[b*8 +: 8];
                end
            end
        end
    end

    // Read path; unmapped addresses read as zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_done_r <= 1'b0;
            rdata_r <= 32'h00000000;
        end else if (clk_en) begin
            rd_done_r <= avs_read && !rd_done_r;
            if (avs_read && !rd_done_r) begin
                case (avs_address)
                    cmsc_pkg::TUNING_ADDR: rdata_r <= tuning_r;
                    cmsc_pkg::STATUS_ADDR: rdata_r <= {31'h00000000, zc_sel};
                    default: rdata_r <= 32'h00000000;
                endcase
            end
        end
    end
    assign avs_readdata = rdata_r;

    // ----------------------------------------------------------------
    // Field decode into registered outputs; window and enable bits pass straight through
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            demag_cnt_r <= 5'h00;
            demag_up_r <= 8'h00;
            demag_lo_r <= 8'h00;
            fall_r <= 12'h000;
            rise_r <= 12'h000;
        end else if (clk_en) begin
            demag_cnt_r <= cmsc_pkg::DCNT_TBL[tuning_r[cmsc_pkg::DCNT_POS +: 2]];
            demag_up_r <= cmsc_pkg::DUP_TBL[tuning_r[cmsc_pkg::DUP_POS +: 2]];
            demag_lo_r <= cmsc_pkg::DLO_TBL[tuning_r[cmsc_pkg::DLO_POS +: 2]];
            fall_r <= thr_decode(tuning_r[cmsc_pkg::FALL_POS +: 6]);
            rise_r <= thr_decode(tuning_r[cmsc_pkg::RISE_POS +: 6]);
        end
    end
    assign demag_check_sample_count = demag_cnt_r;
    assign demag_upper_bound = demag_up_r;
    assign demag_lower_bound = demag_lo_r;
    assign falling_phase_integ_limit = fall_r;
    assign rising_phase_integ_limit = rise_r;
    assign demag_max_window = tuning_r[cmsc_pkg::DWIN_POS +: 2];
    assign dynamic_demag_enable = tuning_r[cmsc_pkg::DEN_POS];

    // ----------------------------------------------------------------
    // Method selection
    // ----------------------------------------------------------------
    // Limits are combinational table lookups; they change only on writes
    assign cfg_bus.sample_count_low_limit = cmsc_pkg::SLO_TBL[tuning_r[cmsc_pkg::SLO_POS +: 2]];
    assign cfg_bus.sample_count_high_limit = cmsc_pkg::SHI_TBL[tuning_r[cmsc_pkg::SHI_POS +: 2]];
    assign cfg_bus.duty_low_limit = cmsc_pkg::DUTY_TBL[tuning_r[cmsc_pkg::DTLO_POS +: 2]];
    assign cfg_bus.duty_high_limit = cmsc_pkg::DUTY_TBL[tuning_r[cmsc_pkg::DTHI_POS +: 2]];

    cmsc_method_sel u_sel (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .cfg(cfg_bus),
        .bemf_samples_per_30deg(bemf_samples_per_30deg),
        .duty_percent(duty_percent),
        .zero_crossing_commutation(zc_sel)
    );
    assign zero_crossing_commutation = zc_sel;
endmodule
`default_nettype wire
